/* File: src/internal_error_status_mask.v */
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "internal_error_defs.vh"

// Notes on behaviour
// - Inbound posted, nonposted, completion time-outs set status bits 0, 1, 2.
// - Outbound posted, nonposted, completion time-outs set status bits 4, 5, 6.
// - Inbound data memory single/double ECC errors set bits 7 and 8.
// - Inbound control memory single/double ECC errors set bits 9 and 10.
// - Outbound data memory single/double ECC errors set bits 11 and 12.
// - Outbound control memory single/double ECC errors set bits 13 and 14.
// - End-to-end data path parity error sets bit 15.
// - Unreliable-link flag becoming set sets bit 16.
// - Replay control memory single/double ECC errors set bits 17 and 18.
// - Status at 0x484 is sticky, resets zero, write-one clears; bit 3, 31:19 zero.
// - Mask at 0x488 has one read/write bit per status bit, reset zero.
// - A set mask bit keeps its status bit from being reported.
// - Masking never blocks or alters status setting or its stored value.
// - Reporting happens only while enable bit 0 at 0x480 is one; resets one.
// - Unmasked set bit reports uncorrectable when its severity bit is one, else correctable.
// - Mask bits 14 to 18 exist too; bits 31:19 reserved.
module internal_error_status_mask #(
	parameter ADDR_WIDTH = 12
) (
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_WIDTH-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Error events from on-chip logic, same clock
	input wire in_posted_timeout,
	input wire in_nonposted_timeout,
	input wire in_completion_timeout,
	input wire out_posted_timeout,
	input wire out_nonposted_timeout,
	input wire out_completion_timeout,
	input wire in_data_single_err,
	input wire in_data_double_err,
	input wire in_ctrl_single_err,
	input wire in_ctrl_double_err,
	input wire out_data_single_err,
	input wire out_data_double_err,
	input wire out_ctrl_single_err,
	input wire out_ctrl_double_err,
	input wire path_parity_err,
	input wire unreliable_link_flag,
	input wire replay_ctrl_single_err,
	input wire replay_ctrl_double_err,
	// Requests toward the error reporting capability
	output wire aer_correctable_req,
	output wire aer_uncorrectable_req
);

	localparam [31:0] VALID = `IERR_VALID_BITS;
	// Offsets widened to 32 bits so the word slice stays legal for any bus width up to 32 bits
	localparam [31:0] CONTROL_BYTE = {20'h00000, `IERR_CONTROL_OFFSET};
	localparam [31:0] STATUS_BYTE = {20'h00000, `IERR_STATUS_OFFSET};
	localparam [31:0] MASK_BYTE = {20'h00000, `IERR_MASK_OFFSET};
	localparam [31:0] SEVERITY_BYTE = {20'h00000, `IERR_SEVERITY_OFFSET};
	localparam [ADDR_WIDTH-3:0] CONTROL_WORD = CONTROL_BYTE[ADDR_WIDTH-1:2];
	localparam [ADDR_WIDTH-3:0] STATUS_WORD = STATUS_BYTE[ADDR_WIDTH-1:2];
	localparam [ADDR_WIDTH-3:0] MASK_WORD = MASK_BYTE[ADDR_WIDTH-1:2];
	localparam [ADDR_WIDTH-3:0] SEVERITY_WORD = SEVERITY_BYTE[ADDR_WIDTH-1:2];

	reg internal_error_report_enable;
	reg [31:0] internal_error_mask;
	reg [31:0] internal_error_severity;
	reg link_flag_seen;
	reg next_report_enable;
	reg [31:0] next_mask;
	reg [31:0] next_severity;
	reg [31:0] read_word;
	reg next_pready;
	reg next_pslverr;
	reg [31:0] next_prdata;
	reg [3:0] sel_vec;

	wire [31:0] internal_error_status;
	wire [31:0] event_vec;
	wire [31:0] clear_vec;
	wire link_flag_rise;
	wire access;
	wire first_access;
	wire write_done;
	wire wr_control;
	wire wr_status;
	wire wr_mask;
	wire wr_severity;
	wire sel_control;
	wire sel_status;
	wire sel_mask;
	wire sel_severity;
	wire mapped;
	wire [ADDR_WIDTH-3:0] word_addr;
	wire [31:0] write_bits;

	// Decode ignores the byte lane bits; every register is one word
	assign word_addr = paddr[ADDR_WIDTH-1:2];
	always @* begin
		case (word_addr)
			CONTROL_WORD: sel_vec = 4'b0001;
			STATUS_WORD: sel_vec = 4'b0010;
			MASK_WORD: sel_vec = 4'b0100;
			SEVERITY_WORD: sel_vec = 4'b1000;
			default: sel_vec = 4'b0000;
		endcase
	end
	assign sel_control = sel_vec[0];
	assign sel_status = sel_vec[1];
	assign sel_mask = sel_vec[2];
	assign sel_severity = sel_vec[3];
	assign mapped = |sel_vec;

	// Access phase; pready is raised on its second cycle
	assign access = psel & penable;
	assign first_access = access & ~pready;
	assign write_done = access & pready & pwrite;
	assign wr_control = write_done & sel_control;
	assign wr_status = write_done & sel_status;
	assign wr_mask = write_done & sel_mask;
	assign wr_severity = write_done & sel_severity;
	// Reserved positions never store a one, so they always read back zero
	assign write_bits = pwdata & VALID;

	// Only a transition counts; a flag that stays set logs once
	assign link_flag_rise = unreliable_link_flag & ~link_flag_seen;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_flag_seen <= 1'b0;
		end else begin
			link_flag_seen <= unreliable_link_flag;
		end
	end

	// Buffer time-outs
	assign event_vec[`IERR_IN_POSTED_TO] = in_posted_timeout;
	assign event_vec[`IERR_IN_NONPOSTED_TO] = in_nonposted_timeout;
	assign event_vec[`IERR_IN_COMPLETION_TO] = in_completion_timeout;
	assign event_vec[3] = 1'b0;
	assign event_vec[`IERR_OUT_POSTED_TO] = out_posted_timeout;
	assign event_vec[`IERR_OUT_NONPOSTED_TO] = out_nonposted_timeout;
	assign event_vec[`IERR_OUT_COMPLETION_TO] = out_completion_timeout;

	// Memory ECC events
	assign event_vec[`IERR_IN_DATA_SBE] = in_data_single_err;
	assign event_vec[`IERR_IN_DATA_DBE] = in_data_double_err;
	assign event_vec[`IERR_IN_CTRL_SBE] = in_ctrl_single_err;
	assign event_vec[`IERR_IN_CTRL_DBE] = in_ctrl_double_err;
	assign event_vec[`IERR_OUT_DATA_SBE] = out_data_single_err;
	assign event_vec[`IERR_OUT_DATA_DBE] = out_data_double_err;
	assign event_vec[`IERR_OUT_CTRL_SBE] = out_ctrl_single_err;
	assign event_vec[`IERR_OUT_CTRL_DBE] = out_ctrl_double_err;

	// Data path and link events
	assign event_vec[`IERR_PATH_PARITY] = path_parity_err;
	assign event_vec[`IERR_UNRELIABLE_LINK] = link_flag_rise;
	assign event_vec[`IERR_REPLAY_CTRL_SBE] = replay_ctrl_single_err;
	assign event_vec[`IERR_REPLAY_CTRL_DBE] = replay_ctrl_double_err;
	assign event_vec[31:19] = 13'h0000;

	// Write-one-to-clear strobes, only at the completing edge
	assign clear_vec = wr_status ? pwdata : 32'h00000000;

	// Status bits take no mask input at all, so masking cannot touch them
	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1) begin : status_bits
			if (VALID[i]) begin : live_bit
				sticky_flag u_flag (
					.pclk(pclk),
					.presetn(presetn),
					.set(event_vec[i]),
					.clear(clear_vec[i]),
					.q(internal_error_status[i])
				);
			end else begin : empty_bit
				assign internal_error_status[i] = 1'b0;
			end
		end
	endgenerate

	// Control register
	always @* begin
		next_report_enable = internal_error_report_enable;
		if (wr_control) begin
			next_report_enable = pwdata[`IERR_CTL_ENABLE_BIT];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			internal_error_report_enable <= 1'b1;
		end else begin
			internal_error_report_enable <= next_report_enable;
		end
	end

	// Mask register
	always @* begin
		next_mask = internal_error_mask;
		if (wr_mask) begin
			next_mask = write_bits;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			internal_error_mask <= `IERR_MASK_RESET;
		end else begin
			internal_error_mask <= next_mask;
		end
	end

	// Severity register
	always @* begin
		next_severity = internal_error_severity;
		if (wr_severity) begin
			next_severity = write_bits;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			internal_error_severity <= `IERR_SEVERITY_RESET;
		end else begin
			internal_error_severity <= next_severity;
		end
	end

	// Read mux; an unmapped word reads zero
	always @* begin
		case (sel_vec)
			4'b0001: read_word = {31'h00000000, internal_error_report_enable};
			4'b0010: read_word = internal_error_status;
			4'b0100: read_word = internal_error_mask;
			4'b1000: read_word = internal_error_severity;
			default: read_word = 32'h00000000;
		endcase
	end

	// APB answer: one wait state, read data captured in the first access cycle
	always @* begin
		next_pready = first_access;
		next_pslverr = first_access & ~mapped;
		next_prdata = 32'h00000000;
		if (first_access && !pwrite) begin
			next_prdata = read_word;
		end
	end

	// Data bus is zero outside the answer cycle so a stale word never leaks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	report_gate #(
		.WIDTH(32)
	) u_report (
		.pclk(pclk),
		.presetn(presetn),
		.enable(internal_error_report_enable),
		.status(internal_error_status),
		.mask(internal_error_mask),
		.severity(internal_error_severity),
		.correctable_req(aer_correctable_req),
		.uncorrectable_req(aer_uncorrectable_req)
	);

endmodule // internal_error_status_mask

/* File: src/internal_error_defs.vh */
`ifndef INTERNAL_ERROR_DEFS_VH
`define INTERNAL_ERROR_DEFS_VH

// Register byte offsets
`define IERR_CONTROL_OFFSET 12'h480
`define IERR_STATUS_OFFSET 12'h484
`define IERR_MASK_OFFSET 12'h488
`define IERR_SEVERITY_OFFSET 12'h48c

// Control register fields
`define IERR_CTL_ENABLE_BIT 0

// Status bit positions
`define IERR_IN_POSTED_TO 0
`define IERR_IN_NONPOSTED_TO 1
`define IERR_IN_COMPLETION_TO 2
`define IERR_OUT_POSTED_TO 4
`define IERR_OUT_NONPOSTED_TO 5
`define IERR_OUT_COMPLETION_TO 6
`define IERR_IN_DATA_SBE 7
`define IERR_IN_DATA_DBE 8
`define IERR_IN_CTRL_SBE 9
`define IERR_IN_CTRL_DBE 10
`define IERR_OUT_DATA_SBE 11
`define IERR_OUT_DATA_DBE 12
`define IERR_OUT_CTRL_SBE 13
`define IERR_OUT_CTRL_DBE 14
`define IERR_PATH_PARITY 15
`define IERR_UNRELIABLE_LINK 16
`define IERR_REPLAY_CTRL_SBE 17
`define IERR_REPLAY_CTRL_DBE 18

// Bits that exist in status, mask and severity; all others read zero
`define IERR_VALID_BITS 32'h0007fff7

// Reset values
`define IERR_CONTROL_RESET 32'h00000001
`define IERR_STATUS_RESET 32'h00000000
`define IERR_MASK_RESET 32'h00000000
`define IERR_SEVERITY_RESET 32'h00000011

`endif

/* File: src/sticky_flag.v */
`timescale 1ns/1ps

// One write-one-to-clear status bit; a set in the clearing cycle wins
module sticky_flag (
	input wire pclk,
	input wire presetn,
	input wire set,
	input wire clear,
	output reg q
);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clear) begin
			q <= 1'b0;
		end
	end

endmodule // sticky_flag

/* File: src/report_gate.v */
`timescale 1ns/1ps

// Splits set, unmasked errors by severity into two report requests
module report_gate #(
	parameter WIDTH = 32
) (
	input wire pclk,
	input wire presetn,
	input wire enable,
	input wire [WIDTH-1:0] status,
	input wire [WIDTH-1:0] mask,
	input wire [WIDTH-1:0] severity,
	output reg correctable_req,
	output reg uncorrectable_req
);

	wire [WIDTH-1:0] live;

	assign live = status & ~mask;

	// Registered so the outputs leave from flops; costs one cycle of lag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			correctable_req <= 1'b0;
			uncorrectable_req <= 1'b0;
		end else begin
			correctable_req <= enable & (|(live & ~severity));
			uncorrectable_req <= enable & (|(live & severity));
		end
	end

endmodule // report_gate

/* File: test/error_source_model.sv */
`timescale 1ns/1ps
// Error sources as one-cycle pulses, indexed by status bit position
module error_source_model (
	input wire pclk,
	input wire [18:0] hit,
	output reg [18:0] ev
);
	initial ev = 19'h0;
	// Link flag drops again, so each hit is a fresh rising edge
	always @(posedge pclk) begin
		ev <= hit;
	end
endmodule // error_source_model

/* File: test/internal_error_status_mask_monitor.sv */
`timescale 1ns/1ps
module internal_error_status_mask_monitor (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire aer_correctable_req,
	input wire aer_uncorrectable_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire mapped = paddr[11:4] == 8'h48;
	wire rd = pready && !pwrite && !pslverr;
	a_ready_follows: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	a_data_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_err_decode: assert property (pready |-> pslverr == !mapped)
		else $error("error flag wrong for address");
	a_status_reserved: assert property (rd && paddr[3:2] == 2'h1 |-> (prdata & 32'hfff80008) == 0)
		else $error("status reserved bits set");
	a_mask_reserved: assert property (rd && paddr[3:2] == 2'h2 |-> (prdata & 32'hfff80008) == 0)
		else $error("mask reserved bits set");
	a_ctrl_reserved: assert property (rd && paddr[3:2] == 2'h0 |-> prdata[31:1] == 31'h0)
		else $error("control reserved bits set");
	a_quiet_reset: assert property ($rose(presetn) |-> !aer_correctable_req && !aer_uncorrectable_req)
		else $error("report request after reset");
endmodule // internal_error_status_mask_monitor
bind internal_error_status_mask internal_error_status_mask_monitor mon (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .aer_correctable_req,
	.aer_uncorrectable_req);

/* File: test/internal_error_status_mask_tb.sv */
`timescale 1ns/1ps
module internal_error_status_mask_tb;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0;
	reg [18:0] hit = 19'h0;
	wire [18:0] ev;
	wire [31:0] prdata;
	wire pready, pslverr, cor_req, unc_req;
	integer err_total = 0, comparisons = 0, cycles = 0, i, seed = 32'h8b88d51a;
	reg [31:0] r;
	reg [33:0] q[$];
	reg [33:0] e;
	always #2.5 pclk = ~pclk;
	error_source_model src (.pclk(pclk), .hit(hit), .ev(ev));
	internal_error_status_mask dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_posted_timeout(ev[0]),
		.in_nonposted_timeout(ev[1]), .in_completion_timeout(ev[2]), .out_posted_timeout(ev[4]),
		.out_nonposted_timeout(ev[5]), .out_completion_timeout(ev[6]),
		.in_data_single_err(ev[7]), .in_data_double_err(ev[8]), .in_ctrl_single_err(ev[9]),
		.in_ctrl_double_err(ev[10]), .out_data_single_err(ev[11]),
		.out_data_double_err(ev[12]), .out_ctrl_single_err(ev[13]),
		.out_ctrl_double_err(ev[14]), .path_parity_err(ev[15]), .unreliable_link_flag(ev[16]),
		.replay_ctrl_single_err(ev[17]), .replay_ctrl_double_err(ev[18]),
		.aer_correctable_req(cor_req), .aer_uncorrectable_req(unc_req));
	task give_verdict;
		begin
			if (err_total == 0 && comparisons > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// Note holds expected error flag, whether data counts, and data
	task apb(input w, input [11:0] a, input [31:0] d, input [31:0] x);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			q.push_back({a[11:4] != 8'h48, !w, x});
			@(posedge pclk);
			penable <= 1'b1;
			// No cycle count assumed; only the bench ceiling ends a hung wait
			do begin
				@(posedge pclk);
			end while (pready !== 1'b1);
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task fire(input [18:0] v);
		begin
			@(posedge pclk);
			hit <= v;
			@(posedge pclk);
			hit <= 19'h0;
			repeat (3) @(posedge pclk);
		end
	endtask
	task chk(input c, input u);
		begin
			comparisons = comparisons + 1;
			if (cor_req !== c || unc_req !== u) begin
				err_total = err_total + 1;
				$display("MISMATCH %0t requests %b%b exp %b%b", $time, cor_req, unc_req, c, u);
			end
		end
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			e = q.pop_front();
			comparisons = comparisons + 1;
			if (pslverr !== e[33] || (e[32] && prdata !== e[31:0])) begin
				err_total = err_total + 1;
				$display("MISMATCH %0t bus %h exp %h", $time, prdata, e[31:0]);
			end
		end
		cycles = cycles + 1;
		if (cycles == 5000) begin
			err_total = err_total + 1;
			$display("MISMATCH %0t timeout", $time);
			give_verdict;
		end
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h480, 0, 32'h1);
		apb(1'b0, 12'h484, 0, 32'h0);
		apb(1'b0, 12'h488, 0, 32'h0);
		apb(1'b0, 12'h48c, 0, 32'h11);
		apb(1'b0, 12'h490, 0, 32'h0);
		apb(1'b1, 12'h47c, 32'hffffffff, 0);
		chk(1'b0, 1'b0);
		for (i = 0; i < 19; i = i + 1) if (i != 3) begin
			fire(19'h1 << i);
			apb(1'b0, 12'h484, 0, 32'h1 << i);
			chk(!(i == 0 || i == 4), i == 0 || i == 4);
			apb(1'b1, 12'h484, 32'h1 << i, 0);
			apb(1'b0, 12'h484, 0, 32'h0);
			chk(1'b0, 1'b0);
		end
		apb(1'b1, 12'h488, 32'hffffffff, 0);
		apb(1'b0, 12'h488, 0, 32'h7fff7);
		fire(19'h7fff7);
		apb(1'b0, 12'h484, 0, 32'h7fff7);
		chk(1'b0, 1'b0);
		for (i = 0; i < 4; i = i + 1) begin
			r = $random(seed) & 32'h7fff7;
			apb(1'b1, 12'h488, r, 0);
			apb(1'b0, 12'h488, 0, r);
			chk(|(32'h7ffe6 & ~r), |(32'h11 & ~r));
		end
		apb(1'b1, 12'h488, 0, 0);
		apb(1'b1, 12'h480, 0, 0);
		apb(1'b0, 12'h480, 0, 32'h0);
		chk(1'b0, 1'b0);
		apb(1'b1, 12'h480, 1, 0);
		apb(1'b1, 12'h484, 0, 0);
		apb(1'b0, 12'h484, 0, 32'h7fff7);
		chk(1'b1, 1'b1);
		r = $random(seed) & 32'h7fff7;
		apb(1'b1, 12'h48c, r, 0);
		apb(1'b0, 12'h48c, 0, r);
		chk(|(32'h7fff7 & ~r), |r);
		// Event lands on the very edge that clears it; the set must win
		fork
			apb(1'b1, 12'h484, 32'h7fff7, 0);
			begin
				repeat (2) @(posedge pclk);
				hit <= 19'h00100;
				@(posedge pclk);
				hit <= 19'h0;
			end
		join
		apb(1'b0, 12'h484, 0, 32'h100);
		// Let the watcher take the last answer before the run ends
		@(posedge pclk);
		give_verdict;
	end
endmodule // internal_error_status_mask_tb
